// ---- dv/lchb_bus_assertions.sv ----
// lchb_bus_assertions.sv: protocol checks on the host bus wires
`timescale 1ns/100ps
module lchb_bus_assertions
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic switch_register_select_n,
   input wire logic hdlc_register_select_n,
   input wire logic wr_n_rw,
   input wire logic rd_n_data_strobe,
   input wire logic addr_latch,
   input wire logic muxed_bus_line_host_oe,
   input wire logic muxed_bus_line_dev_oe,
   input wire logic reset_indicator_out,
   input wire logic external_reset_in
);
   // ---
   // checks
   // ---
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_ext_rst; external_reset_in |-> ##[1:3] reset_indicator_out; endproperty
   a_ext_rst: assert property (p_ext_rst) else $error("no reset indication");
   property p_por; $past(sys_rst) |-> reset_indicator_out [*4]; endproperty
   a_por: assert property (p_por) else $error("power-up stretch short");
   property p_one_sel; !(!switch_register_select_n && !hdlc_register_select_n); endproperty
   a_one_sel: assert property (p_one_sel) else $error("both selects low");
   property p_no_fight; muxed_bus_line_dev_oe |-> !muxed_bus_line_host_oe; endproperty
   a_no_fight: assert property (p_no_fight) else $error("bus driven twice");
   property p_oe_sel; muxed_bus_line_dev_oe |-> $past(!switch_register_select_n || !hdlc_register_select_n);
   endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("drive without select");
   property p_oe_read; $rose(muxed_bus_line_dev_oe) |-> $past(!rd_n_data_strobe && wr_n_rw); endproperty
   a_oe_read: assert property (p_oe_read) else $error("drive outside read");
   property p_rd_drive;
      $fell(rd_n_data_strobe) && wr_n_rw && !reset_indicator_out
         && !(switch_register_select_n && hdlc_register_select_n) |-> ##[1:2] muxed_bus_line_dev_oe;
   endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
   property p_oe_rel; rd_n_data_strobe [*3] |-> !muxed_bus_line_dev_oe; endproperty
   a_oe_rel: assert property (p_oe_rel) else $error("drive after strobe end");
   property p_quiet; reset_indicator_out [*2] |-> !muxed_bus_line_dev_oe; endproperty
   a_quiet: assert property (p_quiet) else $error("drive in reset");
   c_read: cover property ($rose(muxed_bus_line_dev_oe));
   c_hdlc: cover property (!hdlc_register_select_n && !wr_n_rw);
   c_latch: cover property ($fell(addr_latch));
   c_ext: cover property (external_reset_in);
endmodule // lchb_bus_assertions

// ---- dv/line_card_host_bus_interface_tb_top.sv ----
// line_card_host_bus_interface_tb_top.sv: bench joining host and device ends
`timescale 1ns/100ps
module line_card_host_bus_interface_tb_top;
   logic sys_clk, sys_rst, bus_style, use_muxed, hold_reset, req, req_write, req_space, irq_pending;
   logic watchdog_reset, soft_reset, hdlc_dma_mode, wr_strobe, rd_strobe, reg_space, muxed_mode;
   logic mode_known, hdlc_dma_req, in_reset, busy, done, irq_seen, cap_wr, cap_space;
   logic [7:0] rd_data, req_addr, req_data, reg_addr, wr_data, rsp_data, cap_addr, cap_data, port0_value;
   logic [3:0] port1_dir_out, port1_out, port1_drive, port1_oe, port1_value, p1_ext;
   int n_fail, num_checks;
   lchb_bus_if u_lchb_bus_if();
   lchb_device u_lchb_device(.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(u_lchb_bus_if), .bus_style(bus_style),
      .rd_data(rd_data), .irq_pending(irq_pending), .watchdog_reset(watchdog_reset), .soft_reset(soft_reset),
      .port1_dir_out(port1_dir_out), .port1_out(port1_out), .hdlc_dma_mode(hdlc_dma_mode),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .reg_space(reg_space), .reg_addr(reg_addr),
      .wr_data(wr_data), .port0_value(port0_value), .port1_value(port1_value), .port1_drive(port1_drive),
      .port1_oe(port1_oe), .muxed_mode(muxed_mode), .mode_known(mode_known), .hdlc_dma_req(hdlc_dma_req),
      .in_reset(in_reset));
   lchb_host u_lchb_host(.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(u_lchb_bus_if), .bus_style(bus_style),
      .use_muxed(use_muxed), .hold_reset(hold_reset), .req(req), .req_write(req_write), .req_space(req_space),
      .req_addr(req_addr), .req_data(req_data), .busy(busy), .done(done), .rsp_data(rsp_data),
      .irq_seen(irq_seen));
   lchb_bus_assertions u_chk(.sys_clk(sys_clk), .sys_rst(sys_rst),
      .switch_register_select_n(u_lchb_bus_if.switch_register_select_n),
      .hdlc_register_select_n(u_lchb_bus_if.hdlc_register_select_n), .wr_n_rw(u_lchb_bus_if.wr_n_rw),
      .rd_n_data_strobe(u_lchb_bus_if.rd_n_data_strobe), .addr_latch(u_lchb_bus_if.addr_latch),
      .muxed_bus_line_host_oe(u_lchb_bus_if.muxed_bus_line_host_oe),
      .muxed_bus_line_dev_oe(u_lchb_bus_if.muxed_bus_line_dev_oe),
      .reset_indicator_out(u_lchb_bus_if.reset_indicator_out),
      .external_reset_in(u_lchb_bus_if.external_reset_in));
   // port pins: device drive wins where enabled
   assign u_lchb_bus_if.bidir_port_one_line_in = (port1_oe & port1_drive) | (~port1_oe & p1_ext);
   initial
   begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      if (wr_strobe || rd_strobe)
      begin
         cap_wr <= wr_strobe;
         cap_space <= reg_space;
         cap_addr <= reg_addr;
         cap_data <= wr_data;
      end
   end
   // ---
   // tasks
   // ---
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task wait_ind;
      for (int i = 0; i < 60 && u_lchb_bus_if.reset_indicator_out !== 1'b0; i++) step(1);
      if (u_lchb_bus_if.reset_indicator_out !== 1'b0)
      begin
         n_fail++;
         summarize;
      end
   endtask
   task do_reset(input logic st, input logic mx);
      sys_rst = 1;
      bus_style = st;
      use_muxed = mx;
      step(8);
      sys_rst = 0;
      wait_ind;
   endtask
   task acc(input logic w, input logic sp, input logic [7:0] a, input logic [7:0] d, input bit full);
      req_write = w;
      req_space = sp;
      req_addr = a;
      req_data = d;
      rd_data = ~d;
      req = 1;
      step(1);
      req = 0;
      chk("busy", 8'h01, {7'h0, busy});
      for (int i = 0; i < 40 && done !== 1'b1; i++) step(1);
      if (done !== 1'b1)
      begin
         n_fail++;
         summarize;
      end
      step(3);
      if (full)
      begin
         chk("kind", {7'h0, w}, {7'h0, cap_wr});
         chk("space", {7'h0, sp}, {7'h0, cap_space});
         chk("addr", a, cap_addr);
         if (w)
            chk("wdata", d, cap_data);
         else
            chk("rdata", ~d, rsp_data);
      end
   endtask
   task t_sep;
      do_reset(lchb_pkg::BUS_STYLE_SEP, 1'b0);
      acc(1'b1, lchb_pkg::SPACE_SWITCH, 8'h5a, 8'hc3, 1);
      p1_ext = 4'h9;
      acc(1'b0, lchb_pkg::SPACE_HDLC, 8'ha5, 8'h3c, 1);
      chk("port1_in", 8'h09, {4'h0, port1_value});
      chk("muxed", 8'h00, {7'h0, muxed_mode});
      $display("test sep done");
   endtask
   task t_sep_mux;
      do_reset(lchb_pkg::BUS_STYLE_SEP, 1'b1);
      acc(1'b0, lchb_pkg::SPACE_HDLC, 8'h3c, 8'h69, 1);
      chk("muxed", 8'h01, {7'h0, muxed_mode});
      chk("port0_in", 8'h3c, port0_value);
      $display("test sep mux done");
   endtask
   task t_comb;
      do_reset(lchb_pkg::BUS_STYLE_COMB, 1'b1);
      port1_dir_out = 4'h5;
      port1_out = 4'hf;
      acc(1'b0, lchb_pkg::SPACE_SWITCH, 8'h81, 8'h7e, 1);
      acc(1'b1, lchb_pkg::SPACE_HDLC, 8'hff, 8'h00, 1);
      chk("muxed", 8'h01, {7'h0, muxed_mode});
      chk("port0_in", 8'hff, port0_value);
      chk("port1_mix", 8'h0d, {4'h0, port1_value});
      chk("port1_oe", 8'h05, {4'h0, port1_oe});
      chk("port1_drv", 8'h05, {4'h0, port1_drive & port1_oe});
      use_muxed = 0;
      acc(1'b1, lchb_pkg::SPACE_SWITCH, 8'h00, 8'h55, 0);
      chk("muxed_kept", 8'h01, {7'h0, muxed_mode});
      $display("test comb done");
   endtask
   task t_rst;
      for (int k = 0; k < 3; k++)
      begin
         {soft_reset, watchdog_reset, hold_reset} = 3'h1 << k;
         step(4);
         chk("indicator", 8'h01, {7'h0, u_lchb_bus_if.reset_indicator_out});
         chk("in_reset", 8'h01, {7'h0, in_reset});
         {soft_reset, watchdog_reset, hold_reset} = 3'h0;
         wait_ind;
         chk("mode_known", 8'h00, {7'h0, mode_known});
      end
      $display("test reset done");
   endtask
   task t_irq;
      irq_pending = 1;
      step(4);
      chk("irq_oe", 8'h01, {7'h0, u_lchb_bus_if.irq_n_oe});
      chk("irq_seen", 8'h01, {7'h0, irq_seen});
      hdlc_dma_mode = 1;
      step(4);
      chk("dma_req", 8'h01, {7'h0, hdlc_dma_req});
      chk("irq_dma", 8'h00, {7'h0, u_lchb_bus_if.irq_n_oe});
      {irq_pending, hdlc_dma_mode} = 2'h0;
      step(4);
      chk("irq_off", 8'h00, {7'h0, u_lchb_bus_if.irq_n_oe});
      $display("test irq done");
   endtask
   initial
   begin
      {bus_style, use_muxed, hold_reset, req, req_write, req_space} = 6'h0;
      {irq_pending, watchdog_reset, soft_reset, hdlc_dma_mode, sys_rst} = 5'h1;
      {rd_data, req_addr, req_data} = 24'h0;
      {port1_dir_out, port1_out, p1_ext} = 12'h0;
      n_fail = 0;
      num_checks = 0;
      t_sep;
      t_sep_mux;
      t_comb;
      t_rst;
      t_irq;
      summarize;
   end
endmodule // line_card_host_bus_interface_tb_top

// ---- rtl/lchb_bus_if.sv ----
// lchb_bus_if.sv: pins between host processor and line card controller
`timescale 1ns/100ps
interface lchb_bus_if;
   logic switch_register_select_n;
   logic hdlc_register_select_n;
   logic wr_n_rw;
   logic rd_n_data_strobe;
   logic addr_latch;
   logic [7:0] muxed_bus_line_host;
   logic muxed_bus_line_host_oe;
   logic [7:0] muxed_bus_line_dev;
   logic muxed_bus_line_dev_oe;
   logic [7:0] host_address_line;
   logic [3:0] bidir_port_one_line_in;
   logic irq_n_oe;
   logic reset_indicator_out;
   logic external_reset_in;
   modport device
   (
      input switch_register_select_n, hdlc_register_select_n, wr_n_rw, rd_n_data_strobe, addr_latch,
      input muxed_bus_line_host, muxed_bus_line_host_oe, host_address_line, external_reset_in,
      output muxed_bus_line_dev, muxed_bus_line_dev_oe, irq_n_oe, reset_indicator_out,
      input bidir_port_one_line_in
   );
   modport host
   (
      output switch_register_select_n, hdlc_register_select_n, wr_n_rw, rd_n_data_strobe, addr_latch,
      output muxed_bus_line_host, muxed_bus_line_host_oe, host_address_line, external_reset_in,
      input muxed_bus_line_dev, muxed_bus_line_dev_oe, irq_n_oe, reset_indicator_out
   );
endinterface

// ---- rtl/lchb_device.sv ----
// lchb_device.sv: controller end of the host bus, decoding accesses into user strobes
// Notes on behaviour
// - switch select low reaches non-HDLC registers
// - HDLC select low reaches HDLC registers
// - separate strobes or read/write plus data strobe
// - separate style: write strobe low writes
// - separate style: read strobe low drives data
// - combined style: read/write high reads
// - combined style: strobe rise ends access
// - bus muxed or data only; drive reads
// - latch transparent while ale high, falls captures
// - first access after reset picks bus mode
// - demuxed mode: host gives dedicated address
// - muxed mode: address inputs are input port
// - four-line bidirectional port, captured on read or data strobe fall, not on a separate-style write strobe
// - interrupt pulled low while any pending, not in reset or DMA mode
// - reset indicator high during any reset
// - external reset high holds device in reset
// - HDLC buffers by interrupt or DMA
`timescale 1ns/100ps
module lchb_device
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   lchb_bus_if.device bus,
   input wire logic bus_style,
   input wire logic [7:0] rd_data,
   input wire logic irq_pending,
   input wire logic watchdog_reset,
   input wire logic soft_reset,
   input wire logic [3:0] port1_dir_out,
   input wire logic [3:0] port1_out,
   input wire logic hdlc_dma_mode,
   output logic wr_strobe,
   output logic rd_strobe,
   output logic reg_space,
   output logic [7:0] reg_addr,
   output logic [7:0] wr_data,
   output logic [7:0] port0_value,
   output logic [3:0] port1_value,
   output logic [3:0] port1_drive,
   output logic [3:0] port1_oe,
   output logic muxed_mode,
   output logic mode_known,
   output logic hdlc_dma_req,
   output logic in_reset
);
   // ----------------------------------------
   // reset
   // ----------------------------------------
   logic [3:0] por_cnt;
   logic any_reset;
   assign any_reset = bus.external_reset_in | watchdog_reset | soft_reset | (por_cnt != 4'h0);
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         por_cnt <= lchb_pkg::POR_CYC;
      else if (por_cnt != 4'h0)
         por_cnt <= por_cnt - 4'h1;
   end
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         in_reset <= 1'b1;
         bus.reset_indicator_out <= 1'b1;
      end
      else
      begin
         in_reset <= any_reset;
         bus.reset_indicator_out <= any_reset;
      end
   end
   // ----------------------------------------
   // access decode
   // ----------------------------------------
   logic sel;
   logic strobe_act;
   logic strobe_act_d;
   logic ale_d;
   logic is_write;
   logic acc_write;
   assign sel = ~bus.switch_register_select_n | ~bus.hdlc_register_select_n;
   always_comb
   begin
      if (bus_style == lchb_pkg::BUS_STYLE_SEP)
      begin
         strobe_act = sel & (~bus.wr_n_rw | ~bus.rd_n_data_strobe);
         is_write = ~bus.wr_n_rw;
      end
      else
      begin
         strobe_act = sel & ~bus.rd_n_data_strobe;
         is_write = ~bus.wr_n_rw;
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         strobe_act_d <= 1'b0;
         ale_d <= 1'b0;
         acc_write <= 1'b0;
      end
      else
      begin
         strobe_act_d <= strobe_act;
         // ale high at any time since the last access start; a new high wins over the clear
         if (bus.addr_latch)
            ale_d <= 1'b1;
         else if (strobe_act && !strobe_act_d)
            ale_d <= 1'b0;
         // access kind kept from the start: the separate-style write strobe is gone at the end
         if (strobe_act && !strobe_act_d)
            acc_write <= is_write;
      end
   end
   // ----------------------------------------
   // bus mode strap
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode_known <= 1'b0;
         muxed_mode <= 1'b0;
      end
      else if (any_reset)
      begin
         mode_known <= 1'b0;
         muxed_mode <= 1'b0;
      end
      else if (!mode_known && strobe_act && !strobe_act_d)
      begin
         // ale seen high since last access marks muxed mode
         mode_known <= 1'b1;
         muxed_mode <= ale_d | bus.addr_latch;
      end
   end
   // ----------------------------------------
   // address latch
   // ----------------------------------------
   logic [7:0] ale_latch;
   logic [7:0] cur_addr;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         ale_latch <= 8'h00;
      else if (bus.addr_latch)
         ale_latch <= bus.muxed_bus_line_host;
   end
   // while ale is high the latch is transparent
   assign cur_addr = bus.addr_latch ? bus.muxed_bus_line_host : ale_latch;
   // ----------------------------------------
   // access strobes and user side
   // ----------------------------------------
   logic use_mux;
   assign use_mux = mode_known ? muxed_mode : (ale_d | bus.addr_latch);
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_strobe <= 1'b0;
         rd_strobe <= 1'b0;
         reg_space <= lchb_pkg::SPACE_SWITCH;
         reg_addr <= 8'h00;
         wr_data <= 8'h00;
      end
      else
      begin
         rd_strobe <= 1'b0;
         wr_strobe <= 1'b0;
         if (!any_reset && strobe_act && !strobe_act_d)
         begin
            reg_space <= bus.switch_register_select_n ? lchb_pkg::SPACE_HDLC : lchb_pkg::SPACE_SWITCH;
            reg_addr <= use_mux ? cur_addr : bus.host_address_line;
            rd_strobe <= ~is_write;
         end
         // write completes when strobe ends so the data is settled
         if (!any_reset && !strobe_act && strobe_act_d && acc_write)
         begin
            wr_strobe <= 1'b1;
            wr_data <= bus.muxed_bus_line_host;
         end
      end
   end
   // ----------------------------------------
   // data drive
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bus.muxed_bus_line_dev <= 8'h00;
         bus.muxed_bus_line_dev_oe <= 1'b0;
      end
      else
      begin
         bus.muxed_bus_line_dev <= rd_data;
         bus.muxed_bus_line_dev_oe <= !any_reset && strobe_act && !is_write;
      end
   end
   // ----------------------------------------
   // parallel ports
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         port0_value <= 8'h00;
         port1_value <= 4'h0;
      end
      else if (strobe_act && !strobe_act_d && !bus.rd_n_data_strobe)
      begin
         if (use_mux)
            port0_value <= bus.host_address_line;
         port1_value <= bus.bidir_port_one_line_in;
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         port1_oe <= 4'h0;
         port1_drive <= 4'h0;
      end
      else
      begin
         port1_oe <= any_reset ? 4'h0 : port1_dir_out;
         port1_drive <= port1_out;
      end
   end
   // ----------------------------------------
   // interrupt and dma
   // ----------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bus.irq_n_oe <= 1'b0;
         hdlc_dma_req <= 1'b0;
      end
      else
      begin
         // open drain: enable pulls the shared wire low
         bus.irq_n_oe <= irq_pending & ~any_reset & ~hdlc_dma_mode;
         hdlc_dma_req <= irq_pending & ~any_reset & hdlc_dma_mode;
      end
   end
endmodule // lchb_device

// ---- rtl/lchb_host.sv ----
// lchb_host.sv: host processor end issuing single register accesses
`timescale 1ns/100ps
module lchb_host
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   lchb_bus_if.host bus,
   input wire logic bus_style,
   input wire logic use_muxed,
   input wire logic hold_reset,
   input wire logic req,
   input wire logic req_write,
   input wire logic req_space,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] req_data,
   output logic busy,
   output logic done,
   output logic [7:0] rsp_data,
   output logic irq_seen
);
   lchb_pkg::lchb_host_state_e state;
   logic [1:0] cnt;
   logic wr_q;
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= lchb_pkg::HS_IDLE;
         cnt <= 2'h0;
         busy <= 1'b0;
         done <= 1'b0;
         rsp_data <= 8'h00;
         wr_q <= 1'b0;
         bus.switch_register_select_n <= 1'b1;
         bus.hdlc_register_select_n <= 1'b1;
         bus.wr_n_rw <= 1'b1;
         bus.rd_n_data_strobe <= 1'b1;
         bus.addr_latch <= 1'b0;
         bus.muxed_bus_line_host <= 8'h00;
         bus.muxed_bus_line_host_oe <= 1'b0;
         bus.host_address_line <= 8'h00;
      end
      else
      begin
         done <= 1'b0;
         cnt <= cnt + 2'h1;
         case (state)
            lchb_pkg::HS_IDLE:
            begin
               cnt <= 2'h0;
               if (req && !bus.reset_indicator_out)
               begin
                  busy <= 1'b1;
                  wr_q <= req_write;
                  bus.host_address_line <= req_addr;
                  bus.muxed_bus_line_host <= use_muxed ? req_addr : req_data;
                  bus.muxed_bus_line_host_oe <= use_muxed | req_write;
                  bus.addr_latch <= use_muxed;
                  state <= lchb_pkg::HS_ADDR;
               end
            end
            lchb_pkg::HS_ADDR:
            begin
               if (cnt == lchb_pkg::PHASE_LAST)
               begin
                  bus.addr_latch <= 1'b0;
                  state <= lchb_pkg::HS_LATCH;
                  cnt <= 2'h0;
               end
            end
            lchb_pkg::HS_LATCH:
            begin
               bus.muxed_bus_line_host <= req_data;
               bus.muxed_bus_line_host_oe <= wr_q;
               bus.switch_register_select_n <= req_space != lchb_pkg::SPACE_SWITCH;
               bus.hdlc_register_select_n <= req_space != lchb_pkg::SPACE_HDLC;
               if (bus_style == lchb_pkg::BUS_STYLE_SEP)
               begin
                  bus.wr_n_rw <= ~wr_q;
                  bus.rd_n_data_strobe <= wr_q;
               end
               else
               begin
                  bus.wr_n_rw <= ~wr_q;
                  bus.rd_n_data_strobe <= 1'b0;
               end
               cnt <= 2'h0;
               state <= lchb_pkg::HS_STROBE;
            end
            lchb_pkg::HS_STROBE:
            begin
               if (cnt == lchb_pkg::PHASE_LAST)
               begin
                  rsp_data <= bus.muxed_bus_line_dev;
                  bus.rd_n_data_strobe <= 1'b1;
                  if (bus_style == lchb_pkg::BUS_STYLE_SEP)
                     bus.wr_n_rw <= 1'b1;
                  state <= lchb_pkg::HS_END;
               end
            end
            lchb_pkg::HS_END:
            begin
               bus.switch_register_select_n <= 1'b1;
               bus.hdlc_register_select_n <= 1'b1;
               bus.wr_n_rw <= 1'b1;
               bus.muxed_bus_line_host_oe <= 1'b0;
               busy <= 1'b0;
               done <= 1'b1;
               state <= lchb_pkg::HS_IDLE;
            end
            default:
               state <= lchb_pkg::HS_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bus.external_reset_in <= 1'b0;
         irq_seen <= 1'b0;
      end
      else
      begin
         bus.external_reset_in <= hold_reset;
         irq_seen <= bus.irq_n_oe;
      end
   end
endmodule // lchb_host

// ---- rtl/lchb_pkg.sv ----
// lchb_pkg.sv: shared constants and types for the line card host bus interface
package lchb_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int PORT1_W = 4;
   // bus style strap values
   localparam logic BUS_STYLE_SEP = 1'b0;
   localparam logic BUS_STYLE_COMB = 1'b1;
   // register space select
   localparam logic SPACE_SWITCH = 1'b0;
   localparam logic SPACE_HDLC = 1'b1;
   // host access timing, cycles of sys_clk per phase
   localparam int HOST_PHASE_CYC = 2;
   localparam logic [1:0] PHASE_LAST = 2'h1;
   // power-up reset stretch, cycles
   localparam logic [3:0] POR_CYC = 4'h8;
   typedef enum logic [4:0]
   {
      HS_IDLE = 5'b00001,
      HS_ADDR = 5'b00010,
      HS_LATCH = 5'b00100,
      HS_STROBE = 5'b01000,
      HS_END = 5'b10000
   } lchb_host_state_e;
endpackage
